// File: core/ldsr_pkg.sv
// constants and types for the load diagnostic status register group
// Overview of operation
// - register 0x0A holds ch1 limit in 7:4, ch2 in 3:0, resets 0x11
// - limit code picks half-ohm steps, 0000 is 0.5 ohm, 1001 is 5 ohm
// - register 0x0B holds ch3 limit in 7:4, ch4 in 3:0, resets 0x11
// - 0x0C holds ch1 then ch2 results: ground, supply, open, shorted; reset 0
// - a result bit reads 1 only when that condition was found
// - 0x0D holds ch3 and ch4 results in the same layout, reset 0
// - 0x0E flags line output, ch1 bit 3 down to ch4 bit 0, 7:4 zero
// - 0x0F holds 2-bit state per channel, ch1 highest, resets 0x55
// - state codes: 00 play, 01 high impedance, 10 muted, 11 diagnosing
// - 0x10 holds overcurrent flags in 7:4 and dc-fault flags in 3:0
// - a fault flag reads 1 while its fault is detected on the channel
// - unless skipped, diagnose on leaving high impedance and after a fault
// - line output results are set only while the line check is enabled
package ldsr_pkg;

    localparam logic [6:0] DEV_ADDR        = 7'h2A; // arbitrary value
    localparam logic [7:0] OFS_THRESH_12   = 8'h0A;
    localparam logic [7:0] OFS_THRESH_34   = 8'h0B;
    localparam logic [7:0] OFS_RESULT_12   = 8'h0C;
    localparam logic [7:0] OFS_RESULT_34   = 8'h0D;
    localparam logic [7:0] OFS_LINE_OUT    = 8'h0E;
    localparam logic [7:0] OFS_STATE       = 8'h0F;
    localparam logic [7:0] OFS_FAULT       = 8'h10;
    localparam logic [7:0] RST_THRESH      = 8'h11;
    localparam logic [7:0] RST_RESULT      = 8'h00;
    localparam logic [7:0] RST_STATE       = 8'h55;
    localparam logic [3:0] RST_FLAGS       = 4'h0;
    localparam logic [1:0] ST_PLAY         = 2'h0;
    localparam logic [1:0] ST_HIZ          = 2'h1;
    localparam logic [1:0] ST_MUTE         = 2'h2;
    localparam logic [1:0] ST_DIAG         = 2'h3;
    localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
    localparam logic [3:0] ACK_SLOT        = 4'h9;

    typedef enum logic [4:0] {
        I_IDLE = 5'h01,
        I_DEV  = 5'h02,
        I_PTR  = 5'h04,
        I_WDAT = 5'h08,
        I_RDAT = 5'h10
    } ldsr_bus_st_t;

    typedef enum logic [1:0] {
        D_IDLE = 2'h1,
        D_RUN  = 2'h2
    } ldsr_diag_st_t;

    typedef struct packed {
        logic       vld;
        logic [7:0] addr;
        logic [7:0] data;
    } ldsr_wr_t;

    // one channel's measurement, handed in when a run completes
    typedef struct packed {
        logic       short_to_ground_flag;
        logic       short_to_supply_flag;
        logic       open_load_flag;
        logic       line_output_found;
        logic [3:0] load_code;
    } ldsr_chmeas_t;

    typedef struct packed {
        logic [1:0]   scl_s;
        logic [1:0]   sda_s;
        logic         scl_d;
        logic         sda_d;
        ldsr_bus_st_t st;
        logic [3:0]   cnt;
        logic [7:0]   sh;
        logic [7:0]   ptr;
        logic         rd;
        logic         nack;
        logic         oe;
        logic         sda_o;
        ldsr_wr_t     wr;
    } ldsr_bus_s_t;

    typedef struct packed {
        logic [7:0]      thr12;
        logic [7:0]      thr34;
        logic [3:0][3:0] res;
        logic [3:0]      lo;
        logic [3:0][1:0] rep;
        logic [3:0]      oc;
        logic [3:0]      dc;
        logic [3:0][1:0] prev_ctrl;
        logic [3:0]      prev_flt;
        logic [3:0]      pend;
        ldsr_diag_st_t   dst;
        logic [3:0]      mask;
    } ldsr_regs_t;

endpackage : ldsr_pkg

// File: core/ldsr_bus_slave.sv
// two-wire control bus slave with register pointer and auto increment
`timescale 1ns/1ns
`default_nettype none
module ldsr_bus_slave (
    input  wire logic           mclk,
    input  wire logic           rst_n,
    input  wire logic           scl_in,
    input  wire logic           sda_in,
    output logic                sda_out,
    output logic                sda_oe,
    output logic [7:0]          ptr,
    input  wire logic [7:0]     rdata,
    output ldsr_pkg::ldsr_wr_t  wr
);

    ldsr_pkg::ldsr_bus_s_t q_ff;
    ldsr_pkg::ldsr_bus_s_t nxt_q;

    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    always_comb begin
        scl   = q_ff.scl_s[1];
        sda   = q_ff.sda_s[1];
        rise  = scl & ~q_ff.scl_d;
        fall  = ~scl & q_ff.scl_d;
        start = scl & q_ff.scl_d & q_ff.sda_d & ~sda;
        stop  = scl & q_ff.scl_d & ~q_ff.sda_d & sda;
        nxt_q        = q_ff;
        nxt_q.scl_s  = {q_ff.scl_s[0], scl_in};
        nxt_q.sda_s  = {q_ff.sda_s[0], sda_in};
        nxt_q.scl_d  = scl;
        nxt_q.sda_d  = sda;
        nxt_q.sda_o  = 1'b0;
        nxt_q.wr.vld = 1'b0;
        if (start) begin
            nxt_q.st  = ldsr_pkg::I_DEV;
            nxt_q.cnt = 4'h0;
            nxt_q.oe  = 1'b0;
        end else if (stop) begin
            nxt_q.st = ldsr_pkg::I_IDLE;
            nxt_q.oe = 1'b0;
        end else if (q_ff.st != ldsr_pkg::I_IDLE) begin
            if (rise) begin
                if (q_ff.cnt < ldsr_pkg::BITS_PER_BYTE) begin
                    nxt_q.cnt = q_ff.cnt + 4'h1;
                    if (q_ff.st != ldsr_pkg::I_RDAT) begin
                        nxt_q.sh = {q_ff.sh[6:0], sda};
                    end
                end else if (q_ff.cnt == ldsr_pkg::ACK_SLOT
                             && q_ff.st == ldsr_pkg::I_RDAT) begin
                    nxt_q.nack = sda;
                end
            end else if (fall) begin
                if (q_ff.cnt == ldsr_pkg::BITS_PER_BYTE) begin
                    nxt_q.cnt = ldsr_pkg::ACK_SLOT;
                    case (q_ff.st)
                        ldsr_pkg::I_DEV: begin
                            if (q_ff.sh[7:1] == ldsr_pkg::DEV_ADDR) begin
                                nxt_q.oe = 1'b1;
                                nxt_q.rd = q_ff.sh[0];
                            end else begin
                                nxt_q.st = ldsr_pkg::I_IDLE;
                            end
                        end
                        ldsr_pkg::I_PTR: begin
                            nxt_q.ptr = q_ff.sh;
                            nxt_q.oe  = 1'b1;
                        end
                        ldsr_pkg::I_WDAT: begin
                            nxt_q.oe = 1'b1;
                            nxt_q.wr = '{vld: 1'b1, addr: q_ff.ptr,
                                         data: q_ff.sh};
                        end
                        ldsr_pkg::I_RDAT: begin
                            nxt_q.oe  = 1'b0;
                            nxt_q.ptr = q_ff.ptr + 8'h01;
                        end
                        default: nxt_q.st = ldsr_pkg::I_IDLE;
                    endcase
                end else if (q_ff.cnt == ldsr_pkg::ACK_SLOT) begin
                    nxt_q.cnt = 4'h0;
                    nxt_q.oe  = 1'b0;
                    case (q_ff.st)
                        ldsr_pkg::I_DEV: begin
                            if (q_ff.rd) begin
                                nxt_q.st   = ldsr_pkg::I_RDAT;
                                nxt_q.sh   = rdata;
                                nxt_q.oe   = ~rdata[7];
                                nxt_q.nack = 1'b0;
                            end else begin
                                nxt_q.st = ldsr_pkg::I_PTR;
                            end
                        end
                        ldsr_pkg::I_PTR:  nxt_q.st = ldsr_pkg::I_WDAT;
                        ldsr_pkg::I_WDAT: nxt_q.ptr = q_ff.ptr + 8'h01;
                        ldsr_pkg::I_RDAT: begin
                            // master nack ends the read; reads alter only the register pointer
                            if (q_ff.nack) begin
                                nxt_q.st = ldsr_pkg::I_IDLE;
                            end else begin
                                nxt_q.sh = rdata;
                                nxt_q.oe = ~rdata[7];
                            end
                        end
                        default: nxt_q.st = ldsr_pkg::I_IDLE;
                    endcase
                end else if (q_ff.st == ldsr_pkg::I_RDAT) begin
                    nxt_q.sh = {q_ff.sh[6:0], 1'b0};
                    nxt_q.oe = ~q_ff.sh[6];
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
                      st: ldsr_pkg::I_IDLE, default: '0};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign sda_out = q_ff.sda_o;
    assign sda_oe  = q_ff.oe;
    assign ptr     = q_ff.ptr;
    assign wr      = q_ff.wr;

endmodule : ldsr_bus_slave
`default_nettype wire

// File: core/ldsr_top.sv
// load diagnostic thresholds, results, channel state and fault registers
`timescale 1ns/1ns
`default_nettype none
module ldsr_top (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       scl_in,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe,
    input  wire logic [7:0]                 chan_state_ctrl,
    input  wire logic                       skip_auto_diagnostics,
    input  wire logic                       line_output_check_enable,
    input  wire logic [3:0]                 oc_det,
    input  wire logic [3:0]                 dc_det,
    input  wire logic                       meas_vld,
    input  wire ldsr_pkg::ldsr_chmeas_t [3:0] meas,
    output logic [3:0]                      diag_mask
);

    ldsr_pkg::ldsr_regs_t q_ff;
    ldsr_pkg::ldsr_regs_t nxt_q;

    logic [7:0]          ptr;
    logic [7:0]          rdata;
    ldsr_pkg::ldsr_wr_t  wr;
    logic [3:0][1:0]     ctrl;
    logic [3:0][3:0]     thr;
    logic [3:0]          flt;
    logic [3:0]          trig;
    logic [3:0][3:0]     res_upd;
    logic [3:0]          lo_upd;
    logic [3:0][1:0]     rep_nx;
    logic                running;

    assign ctrl    = chan_state_ctrl;
    assign thr     = {q_ff.thr12, q_ff.thr34};
    assign flt     = oc_det | dc_det;
    assign running = (q_ff.dst == ldsr_pkg::D_RUN);

    ldsr_bus_slave u_bus (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .sda_out (sda_out),
        .sda_oe  (sda_oe),
        .ptr     (ptr),
        .rdata   (rdata),
        .wr      (wr)
    );

    // index 3 is channel 1 so packed arrays match register bit order
    for (genvar i = 0; i < 4; i++) begin : g_ch
        logic left_hiz;
        logic new_flt;
        logic new_diag;
        logic shorted;
        assign left_hiz = (q_ff.prev_ctrl[i] == ldsr_pkg::ST_HIZ)
                        & (ctrl[i] != ldsr_pkg::ST_HIZ);
        assign new_flt  = flt[i] & ~q_ff.prev_flt[i];
        assign new_diag = (q_ff.prev_ctrl[i] != ldsr_pkg::ST_DIAG)
                        & (ctrl[i] == ldsr_pkg::ST_DIAG);
        // explicit diag request runs even when automatic runs are skipped
        assign trig[i]  = (~skip_auto_diagnostics & (left_hiz | new_flt))
                        | new_diag;
        // codes above 1001 still compare, their meaning is undefined
        assign shorted  = (meas[i].load_code <= thr[i]);
        assign res_upd[i] = q_ff.mask[i]
                          ? {meas[i].short_to_ground_flag,
                             meas[i].short_to_supply_flag,
                             meas[i].open_load_flag,
                             shorted}
                          : q_ff.res[i];
        assign lo_upd[i]  = q_ff.mask[i]
                          ? (line_output_check_enable
                             & meas[i].line_output_found)
                          : q_ff.lo[i];
        assign rep_nx[i]  = (running & q_ff.mask[i])
                          ? ldsr_pkg::ST_DIAG : ctrl[i];
    end

    always_comb begin
        nxt_q           = q_ff;
        nxt_q.prev_ctrl = ctrl;
        nxt_q.prev_flt  = flt;
        nxt_q.oc        = oc_det;
        nxt_q.dc        = dc_det;
        nxt_q.rep       = rep_nx;
        if (wr.vld) begin
            case (wr.addr)
                ldsr_pkg::OFS_THRESH_12: nxt_q.thr12 = wr.data;
                ldsr_pkg::OFS_THRESH_34: nxt_q.thr34 = wr.data;
                default: ; // read-only and unmapped writes dropped
            endcase
        end
        unique case (q_ff.dst)
            ldsr_pkg::D_IDLE: begin
                nxt_q.pend = q_ff.pend | trig;
                if (|q_ff.pend) begin
                    // triggers landing now stay pending, none are lost
                    nxt_q.dst  = ldsr_pkg::D_RUN;
                    nxt_q.mask = q_ff.pend;
                    nxt_q.pend = trig;
                end
            end
            ldsr_pkg::D_RUN: begin
                nxt_q.pend = q_ff.pend | trig;
                if (meas_vld) begin
                    // results change only here
                    nxt_q.res  = res_upd;
                    nxt_q.lo   = lo_upd;
                    nxt_q.dst  = ldsr_pkg::D_IDLE;
                    nxt_q.mask = 4'h0;
                end
            end
        endcase
    end

    // pure mux, a read has no side effect
    always_comb begin
        case (ptr)
            ldsr_pkg::OFS_THRESH_12: rdata = q_ff.thr12;
            ldsr_pkg::OFS_THRESH_34: rdata = q_ff.thr34;
            ldsr_pkg::OFS_RESULT_12:
                rdata = {q_ff.res[3], q_ff.res[2]};
            ldsr_pkg::OFS_RESULT_34:
                rdata = {q_ff.res[1], q_ff.res[0]};
            ldsr_pkg::OFS_LINE_OUT:  rdata = {4'h0, q_ff.lo};
            ldsr_pkg::OFS_STATE:     rdata = q_ff.rep;
            ldsr_pkg::OFS_FAULT:     rdata = {q_ff.oc, q_ff.dc};
            default:                 rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= '{thr12:     ldsr_pkg::RST_THRESH,
                      thr34:     ldsr_pkg::RST_THRESH,
                      res:       {ldsr_pkg::RST_RESULT,
                                  ldsr_pkg::RST_RESULT},
                      lo:        ldsr_pkg::RST_FLAGS,
                      rep:       ldsr_pkg::RST_STATE,
                      oc:        ldsr_pkg::RST_FLAGS,
                      dc:        ldsr_pkg::RST_FLAGS,
                      prev_ctrl: ldsr_pkg::RST_STATE,
                      prev_flt:  ldsr_pkg::RST_FLAGS,
                      pend:      ldsr_pkg::RST_FLAGS,
                      dst:       ldsr_pkg::D_IDLE,
                      mask:      ldsr_pkg::RST_FLAGS};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign diag_mask = q_ff.mask;

endmodule : ldsr_top
`default_nettype wire

// File: bench/ldsr_top_sva.sv
// concurrent checks on the diagnostic register group ports
`timescale 1ns/1ns
`default_nettype none
module ldsr_top_sva (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [7:0] chan_state_ctrl,
    input wire logic       skip_auto_diagnostics,
    input wire logic [3:0] dc_det,
    input wire logic       meas_vld,
    input wire logic [3:0] diag_mask
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_RESET_QUIET: assert property (
        $rose(rst_n) |-> !sda_oe && diag_mask == 4'h0)
        else $error("bus or run active right after reset");
    AST_LEAVE_HIZ: assert property (
        $past(chan_state_ctrl[7:6]) == 2'h1 && chan_state_ctrl[7:6] != 2'h1
        && !skip_auto_diagnostics && diag_mask == 4'h0
        |-> ##[1:3] diag_mask[3])
        else $error("no run after leaving high impedance");
    AST_DIAG_REQ: assert property (
        $past(chan_state_ctrl[1:0]) != 2'h3 && chan_state_ctrl[1:0] == 2'h3
        && diag_mask == 4'h0 |-> ##[1:3] diag_mask[0])
        else $error("no run after explicit request");
    AST_FAULT_RUN: assert property (
        $rose(dc_det[0]) && !skip_auto_diagnostics && diag_mask == 4'h0
        |-> ##[1:3] diag_mask[0])
        else $error("no run after channel fault");
    AST_MASK_HOLD: assert property (
        diag_mask != 4'h0 && !meas_vld |=> $stable(diag_mask))
        else $error("run mask changed before completion");
    AST_MASK_DONE: assert property (
        meas_vld && diag_mask != 4'h0 |=> diag_mask == 4'h0)
        else $error("run did not end after measurement");
    AST_OPEN_DRAIN: assert property (
        sda_out == 1'b0)
        else $error("data pin driven high");
    AST_SDA_SCL_LOW: assert property (
        $changed(sda_oe) |-> !$past(scl_in))
        else $error("data pin changed while bus clock high");
endmodule : ldsr_top_sva
bind ldsr_top ldsr_top_sva u_sva (.mclk(mclk), .rst_n(rst_n),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .chan_state_ctrl(chan_state_ctrl), .dc_det(dc_det),
    .skip_auto_diagnostics(skip_auto_diagnostics),
    .meas_vld(meas_vld), .diag_mask(diag_mask));
`default_nettype wire

// File: bench/ldsr_host.sv
// two-wire bus host model, bus clock stands high between frames
`timescale 1ns/1ns
`default_nettype none
module ldsr_host (
    input  wire logic mclk,
    input  wire logic sda_wire,
    output var logic  scl,
    output var logic  sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic hp(input int n);
        repeat (n) @(posedge mclk);
    endtask : hp
    // data moves one cycle after the clock falls, never beside it
    task automatic bit_io(input logic b, output logic s);
        sda_drv <= b;
        hp(3);
        scl <= 1'b1;
        hp(4);
        s = sda_wire;
        scl <= 1'b0;
        hp(1);
    endtask : bit_io
    // data falls only once the clock has stood high, or no start is seen
    task automatic start;
        sda_drv <= 1'b1;
        hp(3);
        scl <= 1'b1;
        hp(4);
        sda_drv <= 1'b0;
        hp(4);
        scl <= 1'b0;
        hp(1);
    endtask : start
    task automatic stop;
        sda_drv <= 1'b0;
        hp(3);
        scl <= 1'b1;
        hp(4);
        sda_drv <= 1'b1;
        hp(4);
    endtask : stop
    task automatic xfer(input logic [7:0] d, input logic ab,
                        output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(ab, a);
    endtask : xfer
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d,
                          output logic nak);
        logic [7:0] r;
        logic [2:0] n;
        start();
        xfer({ldsr_pkg::DEV_ADDR, 1'b0}, 1'b1, r, n[0]);
        xfer(a, 1'b1, r, n[1]);
        xfer(d, 1'b1, r, n[2]);
        stop();
        nak = |n;
    endtask : wr_reg
    // last read byte is refused by the host to end the transfer
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic nak);
        logic [7:0] r;
        logic [3:0] n;
        start();
        xfer({ldsr_pkg::DEV_ADDR, 1'b0}, 1'b1, r, n[0]);
        xfer(a, 1'b1, r, n[1]);
        start();
        xfer({ldsr_pkg::DEV_ADDR, 1'b1}, 1'b1, r, n[2]);
        xfer(8'hFF, 1'b1, d, n[3]);
        stop();
        nak = |n[2:0];
    endtask : rd_reg
endmodule : ldsr_host
`default_nettype wire

// File: bench/ldsr_top_test.sv
// self-checking bench for the diagnostic register group
`timescale 1ns/1ns
`default_nettype none
module ldsr_top_test;
    logic                         mclk = 1'b0;
    logic                         rst_n = 1'b0;
    logic                         scl;
    logic                         sda_drv;
    wire logic                    sda_wire;
    logic                         sda_out;
    logic                         sda_oe;
    logic [7:0]                   ctrl = 8'h55;
    logic                         skip = 1'b0;
    logic                         lce = 1'b0;
    logic [3:0]                   oc = 4'h0;
    logic [3:0]                   dc = 4'h0;
    logic                         mvld = 1'b0;
    ldsr_pkg::ldsr_chmeas_t [3:0] meas = '0;
    logic [3:0]                   diag_mask;
    int                           fails = 0;
    int                           n_tests = 0;
    assign sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);
    always #25 mclk = ~mclk;
    ldsr_top u_dut (.mclk(mclk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .chan_state_ctrl(ctrl), .skip_auto_diagnostics(skip),
        .line_output_check_enable(lce), .oc_det(oc), .dc_det(dc),
        .meas_vld(mvld), .meas(meas), .diag_mask(diag_mask));
    ldsr_host u_host (.mclk(mclk), .sda_wire(sda_wire), .scl(scl),
        .sda_drv(sda_drv));
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       nak;
        u_host.rd_reg(a, d, nak);
        check({7'h00, nak}, 8'h00);
        check(d, exp);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic nak;
        u_host.wr_reg(a, d, nak);
        check({7'h00, nak}, 8'h00);
    endtask : wr
    task automatic wait_mask(input logic [3:0] exp);
        for (int i = 0; i < 20 && diag_mask !== exp; i++) @(posedge mclk);
        check({4'h0, diag_mask}, {4'h0, exp});
        if (diag_mask !== exp) stop_test();
    endtask : wait_mask
    task automatic end_run(input ldsr_pkg::ldsr_chmeas_t [3:0] v);
        meas <= v;
        mvld <= 1'b1;
        @(posedge mclk);
        mvld <= 1'b0;
        wait_mask(4'h0);
    endtask : end_run
    task automatic t_reset;
        logic [7:0] exp [7] = '{8'h11, 8'h11, 8'h00, 8'h00, 8'h00, 8'h55,
                                8'h00};
        for (int i = 0; i < 7; i++) begin
            rd(8'h0A + 8'(i), exp[i]);
        end
        rd(8'h20, 8'h00);
        $display("test reset values done");
    endtask : t_reset
    // only codes up to 1001 are written, higher ones are undefined
    task automatic t_thresh;
        wr(ldsr_pkg::OFS_THRESH_12, 8'h09);
        wr(ldsr_pkg::OFS_THRESH_34, 8'h90);
        wr(ldsr_pkg::OFS_RESULT_12, 8'hFF);
        rd(ldsr_pkg::OFS_THRESH_12, 8'h09);
        rd(ldsr_pkg::OFS_THRESH_34, 8'h90);
        rd(ldsr_pkg::OFS_RESULT_12, 8'h00);
        $display("test thresholds done");
    endtask : t_thresh
    // ch1..3 leave high impedance, ch4 by a fault; ch1 code sits on its limit and so does ch3, ch2 code is one above and ch4 one above
    task automatic t_diag;
        lce <= 1'b1;
        ctrl <= 8'h01;
        dc <= 4'h1;
        wait_mask(4'hF);
        rd(ldsr_pkg::OFS_STATE, 8'hFF);
        end_run(32'h904A_39F1);
        rd(ldsr_pkg::OFS_RESULT_12, 8'h94);
        rd(ldsr_pkg::OFS_RESULT_12, 8'h94);
        rd(ldsr_pkg::OFS_RESULT_34, 8'h3E);
        rd(ldsr_pkg::OFS_LINE_OUT, 8'h0B);
        rd(ldsr_pkg::OFS_STATE, 8'h01);
        $display("test automatic run done");
    endtask : t_diag
    task automatic t_skip;
        skip <= 1'b1;
        lce <= 1'b0;
        ctrl <= 8'h41;
        repeat (4) @(posedge mclk);
        ctrl <= 8'h01;
        repeat (8) @(posedge mclk);
        check({4'h0, diag_mask}, 8'h00);
        ctrl <= 8'h03;
        wait_mask(4'h1);
        end_run(32'hFFFF_FF30);
        rd(ldsr_pkg::OFS_RESULT_12, 8'h94);
        rd(ldsr_pkg::OFS_RESULT_34, 8'h33);
        rd(ldsr_pkg::OFS_LINE_OUT, 8'h0A);
        $display("test bypass and request done");
    endtask : t_skip
    task automatic t_faults;
        oc <= 4'hA;
        dc <= 4'h5;
        rd(ldsr_pkg::OFS_FAULT, 8'hA5);
        wr(ldsr_pkg::OFS_FAULT, 8'h00);
        rd(ldsr_pkg::OFS_FAULT, 8'hA5);
        oc <= 4'h0;
        dc <= 4'h0;
        rd(ldsr_pkg::OFS_FAULT, 8'h00);
        $display("test fault flags done");
    endtask : t_faults
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        t_thresh();
        t_diag();
        t_skip();
        t_faults();
        stop_test();
    end
endmodule : ldsr_top_test
`default_nettype wire
